/* File: rtl/sscs_pkg.sv */
/*
  Package for the six-step commutation sequencer: register offsets, field
  positions, reset values and enumerations. It assumes 8-bit register data
  and a 5-bit register address on a plain strobe port.
*/
`default_nettype none
package sscs_pkg;
  typedef enum logic [1:0] {st_idle, st_wait_c, st_wait_d, st_wait_z} sscs_state_type;
  typedef enum logic [1:0] {mux_high, mux_low, mux_both, mux_alt} sscs_mux_type;

  // page 0 (offset of control_a answers on both pages)
  localparam logic [4:0] OFS_TIMER  = 5'h00;
  localparam logic [4:0] OFS_ZPREV  = 5'h01;
  localparam logic [4:0] OFS_ZCUR   = 5'h02;
  localparam logic [4:0] OFS_CCOMP  = 5'h03;
  localparam logic [4:0] OFS_DCOMP  = 5'h04;
  localparam logic [4:0] OFS_WEIGHT = 5'h05;
  localparam logic [4:0] OFS_PRESC  = 5'h06;
  localparam logic [4:0] OFS_STATUS = 5'h07;
  localparam logic [4:0] OFS_CRA    = 5'h08;
  localparam logic [4:0] OFS_CRB    = 5'h09;
  localparam logic [4:0] OFS_PHASE  = 5'h0a;
  localparam logic [4:0] OFS_ZCOMP  = 5'h0b;
  localparam logic [4:0] OFS_PCR    = 5'h0c;
  localparam logic [4:0] OFS_REP    = 5'h0d;
  localparam logic [4:0] OFS_DUTYH  = 5'h0e;
  localparam logic [4:0] OFS_DUTYL  = 5'h0f;
  localparam logic [4:0] OFS_PERH   = 5'h10;
  localparam logic [4:0] OFS_PERL   = 5'h11;
  // page 1
  localparam logic [4:0] OFS_DTG    = 5'h00;
  localparam logic [4:0] OFS_POL    = 5'h01;
  localparam logic [4:0] OFS_PWME   = 5'h02;
  localparam logic [4:0] OFS_CONF   = 5'h03;
  localparam logic [4:0] OFS_ZFILT  = 5'h04;

  localparam int CRA_RUN = 0;
  localparam int CRA_SIMZ = 1;
  localparam int CRA_FORCEC = 2;
  localparam int CRA_PAGE = 7;
  localparam int CRB_EDGE = 0;
  localparam int CRB_INV = 1;
  localparam int CRB_HDM = 2;
  localparam int CRB_SDM = 3;
  localparam int PCR_CENTER = 0;
  localparam int PCR_RUN = 1;
  localparam int PCR_RELEASE = 2;
  localparam int CONF_CHOP_EN = 4;
  localparam int ST_FLAG_LSB = 2;

  localparam logic [7:0] CRA_WMASK   = 8'h83;
  localparam logic [7:0] WEIGHT_RST  = 8'h80;
  localparam logic [7:0] PERH_RST    = 8'h0f;
  localparam logic [7:0] PERL_RST    = 8'hff;
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [3:0] PRESC_MAX   = 4'hf;
  localparam logic [7:0] CAL_LOW     = 8'h40;

  localparam logic [1:0] SEL_A = 2'b00;
  localparam logic [1:0] SEL_B = 2'b01;
  localparam logic [1:0] SEL_C = 2'b10;
  localparam logic [1:0] FORCE_LOW  = 2'b01;
  localparam logic [1:0] FORCE_HIGH = 2'b10;
endpackage : sscs_pkg
`default_nettype wire

/* File: rtl/sscs_pwm_gen.sv */
/*
  12-bit PWM generator with edge or center-aligned counting, shadowed duty
  and period, and a repetition down-counter that paces the update pulse.
  Assumes preload values come from registers on the same clock.
*/
`default_nettype none
module sscs_pwm_gen
  import sscs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic        center,
  input  wire logic [11:0] duty_pre,
  input  wire logic [11:0] period_pre,
  input  wire logic [7:0]  rep_pre,
  output var  logic        pwm,
  output var  logic        update
);
  logic [11:0] cnt;
  logic [11:0] duty;
  logic [11:0] period;
  logic [7:0]  repcnt;
  logic        up;
  logic        reload;
  logic        top;

  assign top = cnt == period;
  assign reload = center ? (!up && cnt == 12'h000) : top;

  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      cnt <= 12'h000;
      up <= 1'b1;
    end else if (!center) begin
      cnt <= top ? 12'h000 : cnt + 12'h001;
      up <= 1'b1;
    end else if (up) begin
      up <= !top;
      cnt <= top ? cnt - 12'h001 : cnt + 12'h001;
    end else begin
      up <= cnt == 12'h000;
      cnt <= cnt == 12'h000 ? 12'h001 : cnt - 12'h001;
    end
  end

  // shadows move only at the update point or while stopped, so a duty change never glitches a period
  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      duty <= duty_pre;
      period <= period_pre;
      repcnt <= rep_pre;
      update <= 1'b0;
    end else begin
      update <= reload && repcnt == 8'h00;
      if (reload && repcnt == 8'h00) begin
        duty <= duty_pre;
        period <= period_pre;
        repcnt <= rep_pre;
      end else if (reload) begin
        repcnt <= repcnt - 8'h01;
      end
    end
  end

  // duty 0 never turns on; duty above period stays on for 100%
  always_ff @(posedge clk) begin
    if (!rstn || !run) begin
      pwm <= 1'b0;
    end else begin
      pwm <= cnt < duty;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_duty_zero: assert property (
    run && $past(run) && duty == 12'h000 |=> !pwm)
    else $error("pwm high with zero duty");
  a_update_rep: assert property (
    update |-> repcnt == rep_pre || $changed(rep_pre))
    else $error("update without repetition reload");
  c_update: cover property (run ##1 update);
endmodule : sscs_pwm_gen
`default_nettype wire

/* File: rtl/sscs_top.sv */
/*
  Six-step commutation sequencer: zero-crossing, commutation and
  demagnetization sequencing, 8-bit delay timer with self-calibrating
  prescaler, sense-input multiplexer and six-channel output manager.
  Assumes one 25 MHz clock, digital comparator outputs on the sense pins,
  and an inverter stage that decodes out/oe into the switch gate drives.
*/
`default_nettype none
module sscs_top
  import sscs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  input  wire logic       phase_sense_a,
  input  wire logic       phase_sense_b,
  input  wire logic       phase_sense_c,
  input  wire logic       emergency_stop_n,
  input  wire logic [1:0] option_force_state,
  output logic      [5:0] switch_out,
  output logic      [5:0] switch_oe,
  output logic            pwm_update_irq
);
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    return a == o;
  endfunction : hit

  logic [2:0]     sense_s1;
  logic [2:0]     sense_s2;
  logic [1:0]     opt_s1;
  logic [1:0]     opt_s2;
  logic [7:0]     cra;
  logic [7:0]     crb;
  logic [7:0]     phase_pre;
  logic [7:0]     dcomp;
  logic [7:0]     zcomp;
  logic [7:0]     weight;
  logic [7:0]     pcr;
  logic [7:0]     rep;
  logic [7:0]     dutyh;
  logic [7:0]     dutyl;
  logic [7:0]     perh;
  logic [7:0]     perl;
  logic [7:0]     dtg;
  logic [7:0]     pol;
  logic [7:0]     pwme;
  logic [7:0]     conf;
  logic [7:0]     zfilt;
  logic [7:0]     rd_val;
  logic [5:0]     sw_en;
  logic [1:0]     sense_sel;
  logic           alt;
  logic [3:0]     flags;
  logic [3:0]     next_flags;
  sscs_state_type state;
  sscs_state_type next_state;
  logic [15:0]    pcnt;
  logic [3:0]     presc;
  logic [7:0]     tmr;
  logic [7:0]     zprev;
  logic [7:0]     zcur;
  logic [7:0]     ccomp;
  logic [2:0]     zcnt;
  logic [3:0]     chcnt;
  logic           chop;
  logic [5:0]     val;
  logic           pwm;
  logic           pwm_upd;

  wire page = cra[CRA_PAGE];
  wire run = cra[CRA_RUN];
  wire simz = cra[CRA_SIMZ];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sense_s1 <= 3'b000;
      sense_s2 <= 3'b000;
      opt_s1 <= 2'b00;
      opt_s2 <= 2'b00;
    end else begin
      sense_s1 <= {phase_sense_c, phase_sense_b, phase_sense_a};
      sense_s2 <= sense_s1;
      opt_s1 <= option_force_state;
      opt_s2 <= opt_s1;
    end
  end

  // control_a sits at the same offset on both pages so the page bit is never lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cra <= REG_RST;
      crb <= REG_RST;
      phase_pre <= REG_RST;
      dcomp <= REG_RST;
      zcomp <= REG_RST;
      weight <= WEIGHT_RST;
      pcr <= REG_RST;
      rep <= REG_RST;
      dutyh <= REG_RST;
      dutyl <= REG_RST;
      perh <= PERH_RST;
      perl <= PERL_RST;
      dtg <= REG_RST;
      pol <= REG_RST;
      pwme <= REG_RST;
      conf <= REG_RST;
      zfilt <= REG_RST;
    end else if (wr) begin
      if (hit(addr, OFS_CRA)) cra <= wdata & CRA_WMASK;
      else if (!page) begin
        if (hit(addr, OFS_CRB)) crb <= wdata;
        else if (hit(addr, OFS_PHASE)) phase_pre <= wdata;
        else if (hit(addr, OFS_DCOMP)) dcomp <= wdata;
        else if (hit(addr, OFS_ZCOMP)) zcomp <= wdata;
        else if (hit(addr, OFS_WEIGHT)) weight <= wdata;
        else if (hit(addr, OFS_PCR)) pcr <= wdata;
        else if (hit(addr, OFS_REP)) rep <= wdata;
        else if (hit(addr, OFS_DUTYH)) dutyh <= wdata;
        else if (hit(addr, OFS_DUTYL)) dutyl <= wdata;
        else if (hit(addr, OFS_PERH)) perh <= wdata;
        else if (hit(addr, OFS_PERL)) perl <= wdata;
      end else begin
        if (hit(addr, OFS_DTG)) dtg <= wdata;
        else if (hit(addr, OFS_POL)) pol <= wdata;
        else if (hit(addr, OFS_PWME)) pwme <= wdata;
        else if (hit(addr, OFS_CONF)) conf <= wdata;
        else if (hit(addr, OFS_ZFILT)) zfilt <= wdata;
      end
    end
  end

  always_comb begin
    rd_val = 8'h00;
    if (hit(addr, OFS_CRA)) rd_val = cra;
    else if (!page) begin
      if (hit(addr, OFS_TIMER)) rd_val = tmr;
      else if (hit(addr, OFS_ZPREV)) rd_val = zprev;
      else if (hit(addr, OFS_ZCUR)) rd_val = zcur;
      else if (hit(addr, OFS_CCOMP)) rd_val = ccomp;
      else if (hit(addr, OFS_DCOMP)) rd_val = dcomp;
      else if (hit(addr, OFS_WEIGHT)) rd_val = weight;
      else if (hit(addr, OFS_PRESC)) rd_val = {4'h0, presc};
      else if (hit(addr, OFS_STATUS)) rd_val = {2'b00, flags, state};
      else if (hit(addr, OFS_CRB)) rd_val = crb;
      else if (hit(addr, OFS_PHASE)) rd_val = {sense_sel, sw_en};
      else if (hit(addr, OFS_ZCOMP)) rd_val = zcomp;
      else if (hit(addr, OFS_PCR)) rd_val = pcr;
      else if (hit(addr, OFS_REP)) rd_val = rep;
      else if (hit(addr, OFS_DUTYH)) rd_val = {4'h0, dutyh[3:0]};
      else if (hit(addr, OFS_DUTYL)) rd_val = dutyl;
      else if (hit(addr, OFS_PERH)) rd_val = {4'h0, perh[3:0]};
      else if (hit(addr, OFS_PERL)) rd_val = perl;
    end else begin
      if (hit(addr, OFS_DTG)) rd_val = dtg;
      else if (hit(addr, OFS_POL)) rd_val = {2'b00, pol[5:0]};
      else if (hit(addr, OFS_PWME)) rd_val = {6'h00, pwme[1:0]};
      else if (hit(addr, OFS_CONF)) rd_val = {3'b000, conf[4:0]};
      else if (hit(addr, OFS_ZFILT)) rd_val = {5'h00, zfilt[2:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) rdata <= 8'h00;
    else rdata <= rd ? rd_val : 8'h00;
  end

  // delay timer: prescaler 2^presc, counter restarted at every Z and C
  wire [15:0] pmask = 16'hffff >> (5'h10 - {1'b0, presc});
  wire        tick = &(pcnt | ~pmask);
  wire [15:0] prod = tmr * weight;
  wire        sense_bit = sense_sel == SEL_A ? sense_s2[0] :
                          sense_sel == SEL_B ? sense_s2[1] :
                          sense_sel == SEL_C ? sense_s2[2] : 1'b0;
  wire        win = !pwm;
  wire        target = crb[CRB_EDGE] ^ crb[CRB_INV];
  wire        z_match = win && sense_bit == target;
  wire        force_c = wr && hit(addr, OFS_CRA) && wdata[CRA_FORCEC] && run
                        && state != st_idle;
  wire        c_evt = (state == st_wait_c && tick && tmr == ccomp) || force_c;
  wire        d_hw = state == st_wait_d && crb[CRB_HDM] && sense_bit != crb[CRB_SDM];
  wire        d_sim = state == st_wait_d && !crb[CRB_HDM] && tick && tmr == dcomp;
  wire        d_evt = d_hw || d_sim;
  wire        z_hw = state == st_wait_z && !simz && z_match && zcnt == zfilt[2:0];
  wire        z_sim = state == st_wait_z && simz && tick && tmr == zcomp;
  wire        z_evt = z_hw || z_sim;
  wire        restart = c_evt || z_evt;
  wire        ovf = tick && tmr == 8'hff && state == st_wait_z;

  always_ff @(posedge clk) begin
    if (!rstn || restart) pcnt <= 16'h0000;
    else pcnt <= pcnt + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (!rstn || restart) tmr <= 8'h00;
    else if (tick && tmr != 8'hff) tmr <= tmr + 8'h01;
  end

  // slow rotor overflows the timer: coarser step; fast rotor: finer step
  always_ff @(posedge clk) begin
    if (!rstn) presc <= 4'h0;
    else if (ovf && presc != PRESC_MAX) presc <= presc + 4'h1;
    else if (z_evt && tmr < CAL_LOW && presc != 4'h0) presc <= presc - 4'h1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      zprev <= 8'h00;
      zcur <= 8'h00;
      ccomp <= 8'h00;
    end else if (z_evt) begin
      zprev <= zcur;
      zcur <= tmr;
      ccomp <= prod[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || state != st_wait_z) zcnt <= 3'b000;
    else if (win) zcnt <= !z_match ? 3'b000 : zcnt == zfilt[2:0] ? zcnt : zcnt + 3'b001;
  end

  always_comb begin
    next_state = state;
    if (!run) next_state = st_idle;
    else case (state)
      st_idle: next_state = st_wait_z;
      st_wait_z: next_state = force_c ? st_wait_d : z_evt ? st_wait_c : st_wait_z;
      st_wait_c: next_state = c_evt ? st_wait_d : st_wait_c;
      st_wait_d: next_state = d_evt && !force_c ? st_wait_z : st_wait_d;
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) state <= st_idle;
    else state <= next_state;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sw_en <= 6'h00;
      sense_sel <= SEL_A;
      alt <= 1'b0;
    end else if (c_evt) begin
      sw_en <= phase_pre[5:0];
      sense_sel <= phase_pre[7:6];
      alt <= !alt;
    end
  end

  // set wins over the write-one clear
  wire [3:0] flag_set = {pwm_upd, z_evt, d_evt, c_evt};
  wire [3:0] flag_clr = wr && !page && hit(addr, OFS_STATUS) ? wdata[5:2] : 4'h0;
  assign next_flags = (flags & ~flag_clr) | flag_set;
  assign pwm_update_irq = flags[3];

  always_ff @(posedge clk) begin
    if (!rstn) flags <= 4'h0;
    else flags <= next_flags;
  end

  sscs_pwm_gen u_pwm (
    .clk        (clk),
    .rstn       (rstn),
    .run        (pcr[PCR_RUN]),
    .center     (pcr[PCR_CENTER]),
    .duty_pre   ({dutyh[3:0], dutyl}),
    .period_pre ({perh[3:0], perl}),
    .rep_pre    (rep),
    .pwm        (pwm),
    .update     (pwm_upd)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      chcnt <= 4'h0;
      chop <= 1'b0;
    end else if (chcnt == conf[3:0]) begin
      chcnt <= 4'h0;
      chop <= !chop;
    end else begin
      chcnt <= chcnt + 4'h1;
    end
  end

  // even channels form the high group, odd ones the low group
  wire         chop_gate = !conf[CONF_CHOP_EN] || chop;
  logic [5:0]  raw;
  logic [5:0]  dt_ok;
  genvar n;
  for (n = 0; n < 6; n++) begin : g_ch
    localparam logic HIGH = (n % 2) == 0;
    logic [7:0] dtc;
    wire mode_hit = pwme[1:0] == mux_both || (pwme[1:0] == mux_high && HIGH) ||
                    (pwme[1:0] == mux_low && !HIGH) ||
                    (pwme[1:0] == mux_alt && (alt ? HIGH : !HIGH));
    assign raw[n] = sw_en[n] && (!mode_hit || pwm) && chop_gate;
    // turn-on is delayed so the pair partner is off first
    always_ff @(posedge clk) begin
      if (!rstn || !raw[n]) dtc <= 8'h00;
      else if (dtc < dtg) dtc <= dtc + 8'h01;
    end
    assign dt_ok[n] = raw[n] && dtc >= dtg;
  end

  always_ff @(posedge clk) begin
    if (!rstn) val <= 6'h00;
    else val <= dt_ok ^ pol[5:0];
  end

  // the pin term is not synchronised on purpose: the stop must act without a clock
  wire force_out = !emergency_stop_n || !pcr[PCR_RELEASE];
  wire force_hiz = opt_s2 != FORCE_LOW && opt_s2 != FORCE_HIGH;
  assign switch_out = force_out ? {6{opt_s2 == FORCE_HIGH}} : val;
  assign switch_oe = force_out && force_hiz ? 6'h00 : 6'h3f;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_phase_apply: assert property (
    c_evt |=> sw_en == $past(phase_pre[5:0]) && sense_sel == $past(phase_pre[7:6]))
    else $error("phase state not applied at commutation");
  a_c_then_d: assert property (
    c_evt && run |=> state == st_wait_d)
    else $error("commutation not followed by demag wait");
  a_d_then_z: assert property (
    d_evt && run && !force_c |=> state == st_wait_z ##1 !c_evt)
    else $error("demag not followed by zero-cross wait");
  a_z_then_c: assert property (
    z_evt && run && !force_c |=> state == st_wait_c && tmr == 8'h00)
    else $error("zero cross did not arm commutation delay");
  a_sim_demag: assert property (
    state == st_wait_d && !crb[CRB_HDM] && tick && tmr == dcomp && run && !force_c
    |=> state == st_wait_z)
    else $error("simulated demag compare missed");
  a_sim_zero: assert property (
    state == st_wait_z && simz && tick && tmr == zcomp && run && !force_c
    |=> state == st_wait_c && zcur == $past(tmr))
    else $error("simulated zero cross compare missed");
  a_z_window: assert property (
    z_evt && !simz |-> !pwm && sense_bit == (crb[CRB_EDGE] ^ crb[CRB_INV]))
    else $error("zero cross taken outside window or wrong edge");
  a_sense_mux: assert property (
    c_evt && phase_pre[7:6] == SEL_C |=> sense_bit == sense_s2[2])
    else $error("sense select did not route phase C");
  a_force_state: assert property (
    !pcr[PCR_RELEASE] && opt_s2 == FORCE_LOW |-> switch_oe == 6'h3f && switch_out == 6'h00)
    else $error("forced low state not driven");
  a_page_read: assert property (
    rd && page && hit(addr, OFS_DTG) && !hit(OFS_DTG, OFS_CRA) |=> rdata == $past(dtg))
    else $error("page one read wrong");
  c_full_cycle: cover property (z_evt ##[1:300] c_evt ##[1:300] d_evt);
  c_force_c: cover property (force_c);
  c_emergency: cover property (!emergency_stop_n && switch_oe == 6'h00);
endmodule : sscs_top
`default_nettype wire

/* File: test/six_step_commutation_sequencer_bench.sv */
/*
  Self-checking bench for the six-step commutation sequencer: register
  tasks on the strobe port, step table, event walk and output forcing.
  Assumes the motor model on the sense pins and a 25 MHz clock.
*/
`default_nettype none
module six_step_commutation_sequencer_bench
  import sscs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk, rstn, wr, rd, emergency_stop_n, pwm_update_irq;
  logic       sense_a, sense_b, sense_c;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [1:0] option_force_state;
  logic [2:0] emf;
  logic [5:0] switch_out, switch_oe;
  int         err_count, tests_run;

  // {sense select, switch enables} for the six steps
  localparam logic [7:0]  STEPS [6] = '{8'h89, 8'h61, 8'h24, 8'h86, 8'h52, 8'h18};
  // short period, full duty, slow demag compare, then start pwm with outputs released
  localparam logic [12:0] CFG [6] = '{{OFS_PERH, 8'h00}, {OFS_PERL, 8'h0a},
    {OFS_DUTYH, 8'h0f}, {OFS_DUTYL, 8'hff}, {OFS_DCOMP, 8'hff}, {OFS_PCR, 8'h06}};

  always #20 clk = ~clk;

  sscs_top i_dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .phase_sense_a(sense_a), .phase_sense_b(sense_b), .phase_sense_c(sense_c),
    .emergency_stop_n(emergency_stop_n), .option_force_state(option_force_state),
    .switch_out(switch_out), .switch_oe(switch_oe), .pwm_update_irq(pwm_update_irq)
  );

  sscs_motor_model i_motor (
    .switch_out(switch_out), .switch_oe(switch_oe), .emf(emf),
    .phase_sense_a(sense_a), .phase_sense_b(sense_b), .phase_sense_c(sense_c)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // a gap cycle after each strobe keeps every strobe a single clean pulse
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  task automatic rreg(input logic [4:0] a);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask : rreg

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    rreg(a);
    check($sformatf("reg %h", a), v, exp);
  endtask : rchk

  // polls the status state field; short states may slip between two polls
  task automatic wait_state(input logic [1:0] s, input int lim);
    v = {6'h00, ~s};
    for (int i = 0; i < lim && v[1:0] !== s; i++) begin
      rreg(OFS_STATUS);
    end
    check("state", {6'h00, v[1:0]}, {6'h00, s});
  endtask : wait_state

  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && pwm_update_irq !== 1'b1; i++) begin
      @(posedge clk);
    end
    #1 check("update flag", {7'h00, pwm_update_irq}, 8'h01);
  endtask : wait_irq

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    #1_000_000;
    err_count++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 8'h00;
    emf = 3'b000;
    emergency_stop_n = 1'b1;
    option_force_state = FORCE_LOW;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(OFS_WEIGHT, WEIGHT_RST);
    rchk(OFS_PERH, PERH_RST);
    rchk(OFS_PERL, PERL_RST);
    rchk(OFS_STATUS, REG_RST);
    rchk(5'h1f, REG_RST);
    wreg(OFS_CRA, 8'h80);
    wreg(OFS_POL, 8'h2a);
    rchk(OFS_POL, 8'h2a);
    wreg(OFS_CRA, 8'h00);
    rchk(OFS_ZPREV, REG_RST);
    foreach (CFG[i]) wreg(CFG[i][12:8], CFG[i][7:0]);
    wait_irq(5000);
    wreg(OFS_STATUS, 8'h20);
    wreg(OFS_REP, 8'hff);
    wait_irq(50);
    wreg(OFS_STATUS, 8'h20);
    wait_irq(3000);
    wreg(OFS_STATUS, 8'h20);
    repeat (100) @(posedge clk);
    check("update flag", {7'h00, pwm_update_irq}, 8'h00);
    wreg(OFS_CRA, 8'h01);
    for (int s = 0; s < 6; s++) begin
      wreg(OFS_PHASE, STEPS[s]);
      wreg(OFS_CRA, 8'h05);
      wait_state(2'd2, 1);
      rchk(OFS_PHASE, STEPS[s]);
      #1 check("switch_out", {2'b00, switch_out}, {2'b00, STEPS[s][5:0] ^ 6'h2a});
    end
    wreg(OFS_CRA, 8'h81);
    wreg(OFS_POL, 8'h00);
    wreg(OFS_CRA, 8'h01);
    wreg(OFS_DUTYH, 8'h00);
    wreg(OFS_DUTYL, 8'h00);
    wreg(OFS_STATUS, 8'h20);
    wait_irq(3000);
    repeat (3) @(posedge clk);
    #1 check("switch_out", {2'b00, switch_out}, 8'h08);
    // fresh reset: the long stall without a window has raised the prescaler
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(OFS_PRESC, REG_RST);
    wreg(OFS_CRA, 8'h80);
    wreg(OFS_PWME, 8'h01);
    wreg(OFS_DTG, 8'h06);
    wreg(OFS_CRA, 8'h00);
    wreg(OFS_PCR, 8'h04);
    wreg(OFS_CRB, 8'h04);
    wreg(OFS_CRA, 8'h01);
    wreg(OFS_PHASE, 8'h89);
    wreg(OFS_CRA, 8'h05);
    wait_state(2'd2, 1);
    #1 check("switch_out", {2'b00, switch_out}, 8'h00);
    repeat (8) @(posedge clk);
    #1 check("switch_out", {2'b00, switch_out}, 8'h01);
    emf <= 3'b100;
    wait_state(2'd3, 20);
    wreg(OFS_CRB, 8'h00);
    wreg(OFS_DCOMP, 8'h40);
    wreg(OFS_ZCOMP, 8'h80);
    repeat (100) @(posedge clk);
    emf <= 3'b000;
    wait_state(2'd1, 20);
    wreg(OFS_CRA, 8'h03);
    wait_state(2'd2, 200);
    wait_state(2'd3, 100);
    wait_state(2'd1, 200);
    wait_state(2'd2, 200);
    emergency_stop_n <= 1'b0;
    #1 check("switch_oe", {2'b00, switch_oe}, 8'h3f);
    check("switch_out", {2'b00, switch_out}, 8'h00);
    option_force_state <= FORCE_HIGH;
    repeat (3) @(posedge clk);
    #1 check("switch_out", {2'b00, switch_out}, 8'h3f);
    option_force_state <= 2'b00;
    repeat (3) @(posedge clk);
    #1 check("switch_oe", {2'b00, switch_oe}, 8'h00);
    emergency_stop_n <= 1'b1;
    option_force_state <= FORCE_LOW;
    wreg(OFS_PCR, 8'h00);
    repeat (3) @(posedge clk);
    #1 check("switch_oe", {2'b00, switch_oe}, 8'h3f);
    check("switch_out", {2'b00, switch_out}, 8'h00);
    stop_test();
  end
endmodule : six_step_commutation_sequencer_bench
`default_nettype wire

/* File: test/sscs_motor_model.sv */
/*
  Behavioural inverter and motor windings: each phase sense follows the
  switch pair of that phase while one conducts, else the back-EMF level
  that the bench commands. Assumes even switch bits are the high side and
  phase A sits on bits 1:0, phase B on 3:2, phase C on 5:4.
*/
`default_nettype none
module sscs_motor_model (
  input  wire logic [5:0] switch_out,
  input  wire logic [5:0] switch_oe,
  input  wire logic [2:0] emf,
  output var  logic       phase_sense_a,
  output var  logic       phase_sense_b,
  output var  logic       phase_sense_c
);
  timeunit 1ns;
  timeprecision 1ns;

  wire logic [5:0] conducting = switch_out & switch_oe;
  logic      [2:0] level;

  // a conducting switch ties the phase to its rail, a floating one shows the back-EMF
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      level[p] = conducting[2*p] ? 1'b1 : (conducting[2*p+1] ? 1'b0 : emf[p]);
    end
  end

  assign {phase_sense_c, phase_sense_b, phase_sense_a} = level;
endmodule : sscs_motor_model
`default_nettype wire
